// File: shared/frsc_pkg.sv
// frsc_pkg: constants and types shared by the flash read stall controller
// assumes: ahb-lite style slave port, 32-bit data, three flash arrays per controller
package frsc_pkg;
  // ------------------------------------------------------------------
  // array select
  // ------------------------------------------------------------------
  localparam int          NUM_ARRAYS       = 3;
  localparam logic [1:0]  ARR_MAIN         = 2'h0;
  localparam logic [1:0]  ARR_INFO_ROW     = 2'h1;
  localparam logic [1:0]  ARR_SECOND_INFO  = 2'h2;
  // ------------------------------------------------------------------
  // address map of one controller (byte address bits above the window)
  // ------------------------------------------------------------------
  localparam int          ADDR_W           = 20;
  localparam int          SEL_LSB          = 18;
  localparam logic [1:0]  SEL_MAIN         = 2'h0;
  localparam logic [1:0]  SEL_MAIN_HI      = 2'h1;
  localparam logic [1:0]  SEL_INFO_ROW     = 2'h2;
  localparam logic [1:0]  SEL_SECOND_INFO  = 2'h3;
  localparam int          INFO_OFS_BIT     = 17;
  // ------------------------------------------------------------------
  // ahb encodings
  // ------------------------------------------------------------------
  localparam logic [1:0]  HTRANS_IDLE      = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic        HRESP_OKAY       = 1'h0;
  localparam logic        HRESP_ERROR      = 1'h1;
  // ------------------------------------------------------------------
  // flash read latency in cycles
  // ------------------------------------------------------------------
  localparam int          READ_WAIT        = 1;
  localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

  typedef enum logic [2:0] {
    FRSC_IDLE,
    FRSC_READ,
    FRSC_STALL,
    FRSC_ERR1,
    FRSC_ERR2,
    FRSC_DONE
  } frsc_state_t;
endpackage : frsc_pkg

// File: src/frsc_busy_sync.sv
// frsc_busy_sync: two flip-flop synchroniser for one array busy flag
// assumes: busy comes from the flash macro, possibly off this clock
`timescale 1ns/10ps
module frsc_busy_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // flag
  input  wire logic busy_async,
  output logic      busy
);
  logic meta;
  logic next_meta;
  logic next_busy;

  always_comb begin
    next_meta = busy_async;
    next_busy = meta;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b0;
      busy <= 1'b0;
    end else begin
      meta <= next_meta;
      busy <= next_busy;
    end
  end
endmodule : frsc_busy_sync

// File: src/frsc_ctrl.sv
// frsc_ctrl: ahb read access controller with optional stall on a busy main flash array
// assumes: one ahb-lite slave port, flash arrays give busy flags and read data;
// one instance per attached flash (main processor flash, radio flash)
`timescale 1ns/10ps
module frsc_ctrl #(                         // one instance per attached flash
  parameter int DATA_W = 32
) (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         reset_n,
  // ahb slave
  input  wire logic                         hsel,
  input  wire logic [frsc_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic                         hready,
  output logic      [DATA_W-1:0]            hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // stall enable from the secure misc control module
  input  wire logic                         stall_enable,
  // flash arrays: busy flags (async) and shared read port
  input  wire logic [frsc_pkg::NUM_ARRAYS-1:0] array_busy_async,
  output logic      [1:0]                   flash_array_sel,
  output logic      [frsc_pkg::ADDR_W-1:0]  flash_addr,
  output logic                              flash_rd,
  input  wire logic [DATA_W-1:0]            flash_rdata
);
  // ------------------------------------------------------------------
  // busy synchronisers, one per array
  // ------------------------------------------------------------------
  logic [frsc_pkg::NUM_ARRAYS-1:0] array_busy;

  genvar gi;
  generate
    for (gi = 0; gi < frsc_pkg::NUM_ARRAYS; gi++) begin : g_sync
      frsc_busy_sync u_sync (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .busy_async (array_busy_async[gi]),
        .busy       (array_busy[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  logic [1:0] dec_sel;
  logic       dec_valid;

  always_comb begin
    dec_valid = 1'b1;
    unique case (haddr[frsc_pkg::SEL_LSB +: 2])
      frsc_pkg::SEL_MAIN,
      frsc_pkg::SEL_MAIN_HI:      dec_sel = frsc_pkg::ARR_MAIN;
      frsc_pkg::SEL_INFO_ROW: begin
        dec_sel   = haddr[frsc_pkg::INFO_OFS_BIT] ? frsc_pkg::ARR_SECOND_INFO
                                                  : frsc_pkg::ARR_INFO_ROW;
      end
      frsc_pkg::SEL_SECOND_INFO: begin
        dec_sel   = frsc_pkg::ARR_MAIN;
        dec_valid = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // access state and request classification
  // ------------------------------------------------------------------
  frsc_pkg::frsc_state_t           state;
  frsc_pkg::frsc_state_t           next_state;
  logic                            addr_phase;
  logic                            accepting;
  logic                            tgt_busy;
  logic                            can_stall;
  logic                            held_busy;
  logic                            take_err;
  logic                            take_stall;
  logic                            take_read;
  logic                            new_req;
  logic [frsc_pkg::NUM_ARRAYS-1:0] arr_hit;
  logic [frsc_pkg::NUM_ARRAYS-1:0] arr_hit_busy;
  logic [frsc_pkg::NUM_ARRAYS-1:0] arr_stallable;

  assign addr_phase = hsel && hready && htrans[1];
  // a new address phase is taken only when nothing is in flight or the
  // previous answer stands; the error completion cycle counts as well
  assign accepting  = (state == frsc_pkg::FRSC_IDLE) ||
                      (state == frsc_pkg::FRSC_DONE) ||
                      (state == frsc_pkg::FRSC_ERR2);

  // ------------------------------------------------------------------
  // per-array view of the request
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < frsc_pkg::NUM_ARRAYS; i++) begin
      arr_hit[i]       = dec_valid && (dec_sel == 2'(i));
      arr_hit_busy[i]  = arr_hit[i] && array_busy[i];
      // the stall path is only wired for the main array; the info row
      // arrays still take the error path, so software must keep off them
      arr_stallable[i] = (2'(i) == frsc_pkg::ARR_MAIN);
    end
  end

  assign tgt_busy  = |arr_hit_busy;
  assign can_stall = stall_enable && (|(arr_hit & arr_stallable));
  assign held_busy = array_busy[flash_array_sel];
  assign new_req   = take_err || take_stall || take_read;

  always_comb begin
    take_err   = 1'b0;
    take_stall = 1'b0;
    take_read  = 1'b0;
    if (addr_phase && accepting) begin
      if (hwrite || !dec_valid) begin
        // writes go through the command path, not this read port
        take_err = 1'b1;
      end else if (tgt_busy && can_stall) begin
        take_stall = 1'b1;
      end else if (tgt_busy) begin
        take_err = 1'b1;
      end else begin
        take_read = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      frsc_pkg::FRSC_IDLE,
      frsc_pkg::FRSC_DONE,
      frsc_pkg::FRSC_ERR2: begin
        next_state = frsc_pkg::FRSC_IDLE;
        if (take_err) begin
          next_state = frsc_pkg::FRSC_ERR1;
        end else if (take_stall) begin
          next_state = frsc_pkg::FRSC_STALL;
        end else if (take_read) begin
          next_state = frsc_pkg::FRSC_READ;
        end
      end
      frsc_pkg::FRSC_STALL: begin
        // busy is seen two cycles late through the synchroniser, so the
        // stall may outlast the flag by that much, never fall short of it
        if (!held_busy) begin
          next_state = frsc_pkg::FRSC_READ;
        end
      end
      frsc_pkg::FRSC_READ: begin
        next_state = frsc_pkg::FRSC_DONE;
      end
      frsc_pkg::FRSC_ERR1: begin
        next_state = frsc_pkg::FRSC_ERR2;
      end
      default: begin
        next_state = frsc_pkg::FRSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= frsc_pkg::FRSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // flash read port
  // ------------------------------------------------------------------
  logic [1:0]                  next_flash_array_sel;
  logic [frsc_pkg::ADDR_W-1:0] next_flash_addr;
  logic                        next_flash_rd;

  always_comb begin
    next_flash_array_sel = flash_array_sel;
    next_flash_addr      = flash_addr;
    next_flash_rd        = 1'b0;
    // the select is kept through a stall so the held array is the one watched
    if (new_req) begin
      next_flash_array_sel = dec_sel;
      next_flash_addr      = haddr;
    end
    if (take_read) begin
      next_flash_rd = 1'b1;
    end
    if ((state == frsc_pkg::FRSC_STALL) && !held_busy) begin
      next_flash_rd = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flash_array_sel <= frsc_pkg::ARR_MAIN;
      flash_addr      <= '0;
      flash_rd        <= 1'b0;
    end else begin
      flash_array_sel <= next_flash_array_sel;
      flash_addr      <= next_flash_addr;
      flash_rd        <= next_flash_rd;
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] next_hrdata;

  always_comb begin
    next_hrdata = hrdata;
    if (state == frsc_pkg::FRSC_READ) begin
      // flash data is taken in the same cycle as the read strobe
      next_hrdata = flash_rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= frsc_pkg::RDATA_RESET[DATA_W-1:0];
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // ------------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------------
  logic next_hreadyout;
  logic next_hresp;

  always_comb begin
    next_hreadyout = hreadyout;
    next_hresp     = hresp;
    unique case (state)
      frsc_pkg::FRSC_IDLE,
      frsc_pkg::FRSC_DONE,
      frsc_pkg::FRSC_ERR2: begin
        // every taken request opens with a wait state; an error shows its
        // response already there, as the two-cycle answer demands
        next_hreadyout = !new_req;
        if (take_err) begin
          next_hresp = frsc_pkg::HRESP_ERROR;
        end else begin
          next_hresp = frsc_pkg::HRESP_OKAY;
        end
      end
      frsc_pkg::FRSC_STALL: begin
        next_hreadyout = 1'b0;
        next_hresp     = frsc_pkg::HRESP_OKAY;
      end
      frsc_pkg::FRSC_READ: begin
        next_hreadyout = 1'b1;
        next_hresp     = frsc_pkg::HRESP_OKAY;
      end
      frsc_pkg::FRSC_ERR1: begin
        next_hreadyout = 1'b1;
        next_hresp     = frsc_pkg::HRESP_ERROR;
      end
      default: begin
        next_hreadyout = 1'b1;
        next_hresp     = frsc_pkg::HRESP_OKAY;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp     <= frsc_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= next_hreadyout;
      hresp     <= next_hresp;
    end
  end
endmodule : frsc_ctrl

// File: dv/frsc_chk.sv
// frsc_chk: ahb answers of frsc_ctrl against busy flags
// assumes: busy is held steady for 3 cycles before an access
`timescale 1ns/10ps
module frsc_chk (
  // clock and reset
  input wire logic                          clk_sys,
  input wire logic                          reset_n,
  // ahb and flash side
  input wire logic                          hsel,
  input wire logic [frsc_pkg::ADDR_W-1:0]   haddr,
  input wire logic [1:0]                    htrans,
  input wire logic                          hwrite,
  input wire logic                          hready,
  input wire logic                          hreadyout,
  input wire logic                          hresp,
  input wire logic                          stall_enable,
  input wire logic [frsc_pkg::NUM_ARRAYS-1:0] array_busy_async,
  input wire logic [1:0]                    flash_array_sel,
  input wire logic                          flash_rd
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic st;
  logic b0;
  logic bi;
  assign st = hsel && hready && htrans[1] && hreadyout && !hwrite;
  assign b0 = array_busy_async[0];
  assign bi = &array_busy_async[2:1];
  sequence s_err;
    hresp && !hreadyout ##1 hresp && hreadyout;
  endsequence
  sequence s_ok;
    !hreadyout ##1 hreadyout && !hresp;
  endsequence
  err_two_cycle_a: assert property ($rose(hresp) |-> s_err)
    else $error("error answer not two cycles");
  read_done_a: assert property (flash_rd |-> s_ok)
    else $error("flash read not completed okay");
  write_err_a: assert property (hsel && hready && htrans[1] && hreadyout && hwrite |=> s_err)
    else $error("write not refused");
  unmapped_err_a: assert property (st && haddr[19:18] == 2'h3 |=> s_err)
    else $error("unmapped read not refused");
  nostall_err_a: assert property (st && !haddr[19] && !stall_enable && b0 && $past(b0, 3) |=> s_err)
    else $error("busy read not refused");
  stall_hold_a: assert property (st && !haddr[19] && stall_enable && b0 && $past(b0, 3)
    |=> (!hreadyout && !hresp) [*3])
    else $error("busy main read not held");
  info_err_a: assert property (st && haddr[19:18] == 2'h2 && bi && $past(bi, 3) |=> s_err)
    else $error("busy info row read not refused");
  busy_read_a: assert property (flash_rd && flash_array_sel == 2'h0 |-> !$past(b0, 3))
    else $error("main array read while busy");
endmodule : frsc_chk
bind frsc_ctrl frsc_chk frsc_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .stall_enable(stall_enable), .array_busy_async(array_busy_async),
  .flash_array_sel(flash_array_sel), .flash_rd(flash_rd));

// File: dv/frsc_flash_model.sv
// frsc_flash_model: three flash arrays behind the controller read port
// assumes: data is taken while flash_rd is high
`timescale 1ns/10ps
module frsc_flash_model (
  // clock
  input  wire logic        clk_sys,
  // read port
  input  wire logic [1:0]  flash_array_sel,
  input  wire logic [19:0] flash_addr,
  input  wire logic        flash_rd,
  output logic      [31:0] flash_rdata
);
  logic tog = 1'b0;
  always @(posedge clk_sys) tog <= ~tog;
  // outside a read the word flips each cycle, so a late sample shows
  assign flash_rdata = {10'h0, flash_array_sel, flash_addr} ^ {32{tog & ~flash_rd}};
endmodule : frsc_flash_model

// File: dv/frsc_ctrl_tb.sv
// frsc_ctrl_tb: reads, refusals and stalls on both controllers
// assumes: busy and stall enable are driven here, flash data by the model
`timescale 1ns/10ps
module frsc_ctrl_tb;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        stall_enable = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [19:0] haddr = 20'h0;
  logic [2:0]  busy = 3'h0;
  logic [31:0] hrdata, hrdata_b, flash_rdata, dat;
  logic [19:0] flash_addr;
  logic [1:0]  flash_array_sel;
  logic        hreadyout, hreadyout_b, hresp, flash_rd, rsp;
  int          fails = 0, total_checks = 0, cyc = 0, n;
  // ----
  // instances: main and radio controllers share stimulus
  // ----
  frsc_ctrl frsc_ctrl_inst (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .stall_enable(stall_enable),
    .array_busy_async(busy), .flash_array_sel(flash_array_sel), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata));
  frsc_ctrl frsc_ctrl_radio_inst (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hreadyout_b), .hrdata(hrdata_b),
    .hreadyout(hreadyout_b), .hresp(), .stall_enable(stall_enable), .array_busy_async(busy),
    .flash_array_sel(), .flash_addr(), .flash_rd(), .flash_rdata(flash_rdata));
  frsc_flash_model frsc_flash_model_inst (.clk_sys(clk_sys), .flash_array_sel(flash_array_sel),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_rdata(flash_rdata));
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic access(input logic [19:0] a, input logic w);
    @(negedge clk_sys);
    {hsel, htrans, haddr, hwrite} = {1'b1, frsc_pkg::HTRANS_NONSEQ, a, w};
    @(negedge clk_sys);
    {hsel, htrans} = 3'h0;
    n = 0;
    while (hreadyout !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    rsp = hresp;
    dat = hrdata;
  endtask : access
  task automatic t_read();
    logic [19:0] a [4] = '{20'h00010, 20'h40024, 20'h80038, 20'ha004c};
    logic [1:0]  s [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    for (int i = 0; i < 4; i++) begin // info rows read only while idle
      access(a[i], 1'b0);
      check("read resp", 32'(rsp), 32'(frsc_pkg::HRESP_OKAY));
      check("read wait", n, 1);
      check("read data", dat, {10'h0, s[i], a[i]});
      check("radio data", hrdata_b, {10'h0, s[i], a[i]});
    end
    $display("test read done");
  endtask : t_read
  task automatic t_err();
    access(20'h00100, 1'b1);
    check("write resp", 32'(rsp), 32'(frsc_pkg::HRESP_ERROR));
    access(20'hc0000, 1'b0);
    check("unmapped resp", 32'(rsp), 32'(frsc_pkg::HRESP_ERROR));
    check("error wait", n, 1);
    $display("test error done");
  endtask : t_err
  task automatic t_busy();
    busy = 3'h7; // program running: all three arrays report busy while the bench reads
    repeat (4) @(negedge clk_sys);
    access(20'h00200, 1'b0);
    check("no stall resp", 32'(rsp), 32'(frsc_pkg::HRESP_ERROR));
    stall_enable = 1'b1;
    access(20'h80000, 1'b0);
    check("info resp", 32'(rsp), 32'(frsc_pkg::HRESP_ERROR));
    access(20'ha0000, 1'b0);
    check("info2 resp", 32'(rsp), 32'(frsc_pkg::HRESP_ERROR));
    fork
      access(20'h00300, 1'b0);
      begin
        repeat (8) @(negedge clk_sys);
        busy = 3'h0;
      end
    join
    check("stall resp", 32'(rsp), 32'(frsc_pkg::HRESP_OKAY));
    check("stall held", 32'(n > 7), 1);
    check("stall data", dat, 32'h00300);
    $display("test busy done");
  endtask : t_busy
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    t_read();
    t_err();
    t_busy();
    close_out();
  end
endmodule : frsc_ctrl_tb
